// ---- mpb_board.sv ----
// board side of the pins: drivers, resistors and floating lines
`timescale 1ns/1ns
module mpb_board #(
  parameter int W = 4
) (
  // clock
  input  wire logic         core_clk,
  // device side
  input  wire logic [W-1:0] out,
  input  wire logic [W-1:0] oen,
  input  wire logic [W-1:0] pu,
  input  wire logic [W-1:0] pd,
  // board drivers
  input  wire logic [W-1:0] extEn,
  input  wire logic [W-1:0] extVal,
  output logic      [W-1:0] pin
);
  logic [W-1:0] floatQ = '0;
  // an open line wanders every cycle
  always_ff @(posedge core_clk) floatQ <= ~floatQ;
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (!oen[i]) pin[i] = out[i];
      else if (extEn[i]) pin[i] = extVal[i];
      else if (pu[i]) pin[i] = 1'b1;
      else if (pd[i]) pin[i] = 1'b0;
      else pin[i] = floatQ[i];
    end
  end
endmodule : mpb_board

// ---- mpb_pkg.sv ----
// constants for the port block with clock pin sharing
package mpb_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0] P2_DATA_OFS  = 8'h02;
  localparam logic [7:0] P3_DATA_OFS  = 8'h03;
  localparam logic [7:0] P4_DATA_OFS  = 8'h04;
  localparam logic [7:0] P2_DIR_OFS   = 8'h22;
  localparam logic [7:0] P3_DIR_OFS   = 8'h23;
  localparam logic [7:0] P4_DIR_OFS   = 8'h24;
  localparam logic [7:0] P2_PU_OFS    = 8'h32;
  localparam logic [7:0] P3_PU_OFS    = 8'h33;
  localparam logic [7:0] P4_PU_OFS    = 8'h34;
  localparam logic [7:0] P2_ALT_OFS   = 8'h42;
  localparam logic [7:0] CLKSEL_OFS   = 8'h50;
  // reset values
  localparam logic [7:0] DIR_RST      = 8'hff;
  localparam logic [7:0] DATA_RST     = 8'h00;
  localparam logic [7:0] PU_RST       = 8'h00;
  localparam logic [7:0] ALT_RST      = 8'h00;
  // implemented bit masks
  localparam logic [7:0] P2_MASK      = 8'h0f;
  localparam logic [7:0] P3_MASK      = 8'h04;
  localparam logic [7:0] P3_PU_MASK   = 8'h14;
  localparam logic [7:0] P4_MASK      = 8'h09;
  // bit positions
  localparam int P2_OSC_OUT_BIT = 2;
  localparam int P2_OSC_IN_BIT  = 3;
  localparam int P3_RST_BIT     = 4;
  localparam int P3_IO_BIT      = 2;
  // clock source from option setting
  typedef enum logic [1:0] {
    MPB_CLK_HSINT,
    MPB_CLK_XTAL,
    MPB_CLK_EXT,
    MPB_CLK_RSVD
  } mpb_clksrc_t;
endpackage : mpb_pkg

// ---- mpb_port_block.sv ----
// port 2, 3 and 4 logic with clock-shared port 2 pins
// What this block does
// - port 2 is four bidirectional pins, each driven by its own latch bit except alternate pins 0-1, which drive timer outputs
// - each port 2 pin has its own direction bit
// - input pin gets pull-up only when its pull-up select bit is set
// - internal oscillator frees both clock-shared pins for port or analog use
// - crystal mode gives both shared pins (only the input pin in non-analog variant) to oscillator, no port or analog
// - external clock takes input pin; output-side pin stays usable
// - clock source comes from option setting at start-up, not a register
// - any reset puts every port 2 pin in input direction
// - during reset both clock-shared pins are pulled down
// - reset-shared port 3 pin is input-only and pulled up during reset
// - port 3 io pin has direction, optional pull-up and feeds interrupt input
// - eight pins in total, seven bidirectional, eight with pull-ups
// - analog variant routes port 2 to analog, timer and interrupt functions
// - non-analog variant frees the ext clock pin when internal oscillator used
// - direction bit 0 means output driver on, 1 means input
// - data read gives pin level for inputs and latch for outputs
// - reset sets all direction registers to all ones
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ns
module mpb_port_block #(
  parameter bit HAS_ADC = 1'b1
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // register port
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  // option setting read at start-up
  input  wire logic [1:0] optClkSrc,
  input  wire logic       optResetPinIsPort,
  // port 2 pins
  input  wire logic [3:0] port2In,
  output logic      [3:0] port2Out,
  output logic      [3:0] port2Oen,
  output logic      [3:0] port2PullUp,
  output logic      [3:0] port2PullDown,
  // port 3 pins
  input  wire logic       port3Pin2In,
  output logic            port3Pin2Out,
  output logic            port3Pin2Oen,
  output logic            port3Pin2PullUp,
  input  wire logic       port3Pin4In,
  output logic            port3Pin4PullUp,
  // port 4 pins
  input  wire logic [1:0] port4In,
  output logic      [1:0] port4Out,
  output logic      [1:0] port4Oen,
  output logic      [1:0] port4PullUp,
  // alternate functions
  output logic      [3:0] analogInputEn,
  output logic            oscInputSel,
  output logic            oscOutputSel,
  input  wire logic       timerOutputA,
  input  wire logic       timerHOutput,
  output logic            extInterrupt0,
  output logic            extInterrupt1,
  output logic            timerCaptureA
);
  logic [7:0] p2Dir_q, p3Dir_q, p4Dir_q;
  logic [7:0] p2Dat_q, p3Dat_q, p4Dat_q;
  logic [7:0] p2Pu_q, p3Pu_q, p4Pu_q;
  logic [7:0] p2Alt_q;
  mpb_pkg::mpb_clksrc_t clkSrc_q;
  logic       rstPort_q;
  logic       optTaken_q;
  logic [7:0] pinSync;
  logic [7:0] pinsRaw;
  logic [7:0] p2Pins, p3Pins, p4Pins;
  logic [3:0] p2OscOwned;
  logic [7:0] rdData_d;
  logic [3:0] p2Drive;
  logic [3:0] p2Alt;

  // pins from the board pass two flops
  assign pinsRaw = {port3Pin4In, port3Pin2In, port4In, port2In};

  mpb_sync #(.W(8)) uSync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .asyncIn  (pinsRaw),
    .syncOut  (pinSync)
  );

  assign p2Pins = {4'h0, pinSync[3:0]};
  assign p4Pins = {4'h0, pinSync[5], 2'h0, pinSync[4]};
  assign p3Pins = {3'h0, pinSync[7], 1'h0, pinSync[6], 2'h0};

  // read mux of pin level or latch per direction bit
  function automatic logic [7:0] portRead(input logic [7:0] dir, input logic [7:0] dat,
                                          input logic [7:0] pins, input logic [7:0] msk);
    portRead = ((dir & pins) | (~dir & dat)) & msk;
  endfunction : portRead

  function automatic logic isWr(input logic [7:0] a, input logic [7:0] ofs);
    isWr = regWr && (regAddr == ofs) && (a == ofs);
  endfunction : isWr

  // option setting taken once after reset release
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      clkSrc_q   <= mpb_pkg::MPB_CLK_HSINT;
      rstPort_q  <= 1'b0;
      optTaken_q <= 1'b0;
    end else if (!optTaken_q) begin
      clkSrc_q   <= mpb_pkg::mpb_clksrc_t'(optClkSrc);
      rstPort_q  <= optResetPinIsPort;
      optTaken_q <= 1'b1;
    end
  end

  // which port 2 pins belong to the oscillator
  always_comb begin
    p2OscOwned = 4'h0;
    case (clkSrc_q)
      mpb_pkg::MPB_CLK_HSINT: p2OscOwned = 4'h0;
      mpb_pkg::MPB_CLK_XTAL: begin
        p2OscOwned[mpb_pkg::P2_OSC_OUT_BIT] = HAS_ADC;
        p2OscOwned[mpb_pkg::P2_OSC_IN_BIT]  = 1'b1;
      end
      mpb_pkg::MPB_CLK_EXT: p2OscOwned[mpb_pkg::P2_OSC_IN_BIT] = 1'b1;
      default: p2OscOwned = 4'h0;
    endcase
  end

  assign oscInputSel  = p2OscOwned[mpb_pkg::P2_OSC_IN_BIT];
  assign oscOutputSel = p2OscOwned[mpb_pkg::P2_OSC_OUT_BIT];

  // direction registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      p2Dir_q <= mpb_pkg::DIR_RST;
      p3Dir_q <= mpb_pkg::DIR_RST;
      p4Dir_q <= mpb_pkg::DIR_RST;
    end else begin
      if (isWr(regAddr, mpb_pkg::P2_DIR_OFS)) p2Dir_q <= regWdata | ~mpb_pkg::P2_MASK;
      if (isWr(regAddr, mpb_pkg::P3_DIR_OFS)) p3Dir_q <= regWdata | ~mpb_pkg::P3_MASK;
      if (isWr(regAddr, mpb_pkg::P4_DIR_OFS)) p4Dir_q <= regWdata | ~mpb_pkg::P4_MASK;
    end
  end

  // output latches
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      p2Dat_q <= mpb_pkg::DATA_RST;
      p3Dat_q <= mpb_pkg::DATA_RST;
      p4Dat_q <= mpb_pkg::DATA_RST;
    end else begin
      if (isWr(regAddr, mpb_pkg::P2_DATA_OFS)) p2Dat_q <= regWdata & mpb_pkg::P2_MASK;
      if (isWr(regAddr, mpb_pkg::P3_DATA_OFS)) p3Dat_q <= regWdata & mpb_pkg::P3_MASK;
      if (isWr(regAddr, mpb_pkg::P4_DATA_OFS)) p4Dat_q <= regWdata & mpb_pkg::P4_MASK;
    end
  end

  // pull-up select and alternate function control
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      p2Pu_q  <= mpb_pkg::PU_RST;
      p3Pu_q  <= mpb_pkg::PU_RST;
      p4Pu_q  <= mpb_pkg::PU_RST;
      p2Alt_q <= mpb_pkg::ALT_RST;
    end else begin
      if (isWr(regAddr, mpb_pkg::P2_PU_OFS))  p2Pu_q  <= regWdata & mpb_pkg::P2_MASK;
      if (isWr(regAddr, mpb_pkg::P3_PU_OFS))  p3Pu_q  <= regWdata & mpb_pkg::P3_PU_MASK;
      if (isWr(regAddr, mpb_pkg::P4_PU_OFS))  p4Pu_q  <= regWdata & mpb_pkg::P4_MASK;
      if (isWr(regAddr, mpb_pkg::P2_ALT_OFS)) p2Alt_q <= regWdata & mpb_pkg::P2_MASK & {8{HAS_ADC}};
    end
  end

  // port 2 drivers, pull-ups and alternates
  assign p2Alt = p2Alt_q[3:0] & ~p2OscOwned;
  always_comb begin
    p2Drive = 4'h0;
    p2Drive[0] = HAS_ADC ? timerHOutput : p2Dat_q[0];
    p2Drive[1] = HAS_ADC ? timerOutputA : p2Dat_q[1];
    p2Drive[2] = p2Dat_q[2];
    p2Drive[3] = p2Dat_q[3];
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : gP2
      // alternate pins 0-1 drive timer output, alternate pins 2-3 keep driver off; output from latch otherwise
      assign port2Out[gi] = (p2Alt[gi] && gi < 2) ? p2Drive[gi] : p2Dat_q[gi];
      assign port2Oen[gi] = !rstn || p2Dir_q[gi] || p2OscOwned[gi] ||
                            (p2Alt[gi] && gi >= 2);
      assign port2PullUp[gi] = rstn && p2Dir_q[gi] && p2Pu_q[gi] &&
                               !p2OscOwned[gi];
      assign analogInputEn[gi] = HAS_ADC && p2Alt[gi] && p2Dir_q[gi];
    end
  endgenerate

  // shared pins pulled down while reset is asserted
  assign port2PullDown = {!rstn, !rstn, 2'b00};

  // port 3
  assign port3Pin2Out    = p3Dat_q[mpb_pkg::P3_IO_BIT];
  assign port3Pin2Oen    = !rstn || p3Dir_q[mpb_pkg::P3_IO_BIT];
  assign port3Pin2PullUp = rstn && p3Dir_q[mpb_pkg::P3_IO_BIT] &&
                           p3Pu_q[mpb_pkg::P3_IO_BIT];
  assign port3Pin4PullUp = !rstn || (rstPort_q && p3Pu_q[mpb_pkg::P3_RST_BIT]);
  assign extInterrupt1   = p3Pins[mpb_pkg::P3_IO_BIT];

  // port 4
  assign port4Out    = {p4Dat_q[3], p4Dat_q[0]};
  assign port4Oen    = {!rstn || p4Dir_q[3], !rstn || p4Dir_q[0]};
  assign port4PullUp = {rstn && p4Dir_q[3] && p4Pu_q[3],
                        rstn && p4Dir_q[0] && p4Pu_q[0]};

  // port 2 inputs to interrupt and timer
  assign extInterrupt0 = p2Pins[1];
  assign timerCaptureA = p2Pins[0] & HAS_ADC;

  // read data
  always_comb begin
    rdData_d = 8'h00;
    case (regAddr)
      mpb_pkg::P2_DATA_OFS: rdData_d = portRead(p2Dir_q, p2Dat_q, p2Pins & ~{4'h0, p2OscOwned},
                                                mpb_pkg::P2_MASK);
      mpb_pkg::P3_DATA_OFS: rdData_d = portRead(p3Dir_q | 8'h10, p3Dat_q,
                                                p3Pins & {3'h0, rstPort_q, 4'hf},
                                                mpb_pkg::P3_PU_MASK);
      mpb_pkg::P4_DATA_OFS: rdData_d = portRead(p4Dir_q, p4Dat_q, p4Pins, mpb_pkg::P4_MASK);
      mpb_pkg::P2_DIR_OFS:  rdData_d = p2Dir_q;
      mpb_pkg::P3_DIR_OFS:  rdData_d = p3Dir_q;
      mpb_pkg::P4_DIR_OFS:  rdData_d = p4Dir_q;
      mpb_pkg::P2_PU_OFS:   rdData_d = p2Pu_q;
      mpb_pkg::P3_PU_OFS:   rdData_d = p3Pu_q;
      mpb_pkg::P4_PU_OFS:   rdData_d = p4Pu_q;
      mpb_pkg::P2_ALT_OFS:  rdData_d = p2Alt_q;
      mpb_pkg::CLKSEL_OFS:  rdData_d = {5'h00, rstPort_q, 2'(clkSrc_q)};
      default:              rdData_d = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      regRdata <= rdData_d;
    end
  end
endmodule : mpb_port_block

// ---- mpb_port_block_bench.sv ----
// self-checking bench for the port block
`timescale 1ns/1ns
module mpb_port_block_bench;
  logic       core_clk, rstn, regWr, regRd, port3Pin2In, port3Pin2Out, port3Pin2Oen;
  logic       port3Pin2PullUp, port3Pin4In, port3Pin4PullUp, oscInputSel, oscOutputSel;
  logic       extInterrupt0, extInterrupt1, timerCaptureA, p3En, p3Ext;
  logic       optRst, tmrA, tmrH;
  logic [7:0] regAddr, regWdata, regRdata, v;
  logic [1:0] optClkSrc, port4In, port4Out, port4Oen, port4PullUp, osc, p4Ext;
  logic [3:0] port2In, port2Out, port2Oen, port2PullUp, port2PullDown, analogInputEn;
  logic [3:0] p2En, p2Ext, dir, lat, pu;
  int         seed, error_cnt, checks_done;
  mpb_port_block dut (.core_clk, .rstn, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .optClkSrc, .optResetPinIsPort(optRst), .port2In, .port2Out, .port2Oen, .port2PullUp,
    .port2PullDown, .port3Pin2In, .port3Pin2Out, .port3Pin2Oen, .port3Pin2PullUp,
    .port3Pin4In, .port3Pin4PullUp, .port4In, .port4Out, .port4Oen, .port4PullUp,
    .analogInputEn, .oscInputSel, .oscOutputSel, .timerOutputA(tmrA), .timerHOutput(tmrH),
    .extInterrupt0, .extInterrupt1, .timerCaptureA);
  mpb_board #(.W(4)) b2 (.core_clk, .out(port2Out), .oen(port2Oen), .pu(port2PullUp),
    .pd(port2PullDown), .extEn(p2En), .extVal(p2Ext), .pin(port2In));
  mpb_board #(.W(1)) b3 (.core_clk, .out(port3Pin2Out), .oen(port3Pin2Oen),
    .pu(port3Pin2PullUp), .pd(1'b0), .extEn(p3En), .extVal(p3Ext), .pin(port3Pin2In));
  mpb_board #(.W(2)) b4 (.core_clk, .out(port4Out), .oen(port4Oen), .pu(port4PullUp),
    .pd(2'b00), .extEn(2'b11), .extVal(p4Ext), .pin(port4In));
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks_done++;
    if (seen !== want) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) {regWr, regAddr, regWdata} <= {1'b1, a, d};
    @(posedge core_clk) regWr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk) {regRd, regAddr} <= {1'b1, a};
    @(posedge core_clk) regRd <= 1'b0;
    #1 v = regRdata;
  endtask : rd
  task automatic do_reset(input logic [1:0] src);
    {rstn, optClkSrc} <= {1'b0, src};
    repeat (3) @(posedge core_clk);
    #1 check({4'h0, port2PullDown}, 8'h0c);
    check({7'h0, port3Pin4PullUp}, 8'h01);
    @(posedge core_clk) rstn <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1 check({4'h0, port2Oen}, 8'h0f);
  endtask : do_reset
  function automatic logic [7:0] exp_data(input logic [3:0] d, l, p);
    return {4'h0, (d & p) | (~d & l)};
  endfunction : exp_data
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #100000 error_cnt++;
    wrap_up();
  end
  initial begin
    seed = 32'h5b36;
    {rstn, regWr, regRd, regAddr, regWdata, optClkSrc} = '0;
    {p2En, p2Ext, p3En, p3Ext, p4Ext, port3Pin4In, optRst, tmrA, tmrH} = '0;
    do_reset(2'd0);
    for (int a = 0; a < 3; a++) begin
      rd(mpb_pkg::P2_DIR_OFS + 8'(a));
      check(v, mpb_pkg::DIR_RST);
    end
    rd(mpb_pkg::P2_PU_OFS);
    check(v, mpb_pkg::PU_RST);
    wr(8'h77, 8'ha5);
    rd(8'h77);
    check(v, 8'h00);
    wr(mpb_pkg::P3_DATA_OFS, 8'h04);
    wr(mpb_pkg::P3_DIR_OFS, 8'h00);
    rd(mpb_pkg::P3_DIR_OFS);
    check(v, 8'hfb);
    repeat (3) @(posedge core_clk);
    #1 check({7'h0, extInterrupt1}, 8'h01);
    for (int i = 0; i < 8; i++) begin
      {dir, lat, pu, p2Ext} = $random(seed);
      if (i < 2) dir = {4{i[0]}};
      p2En <= dir;
      {p4Ext, port3Pin4In} <= 3'($random(seed));
      wr(mpb_pkg::P2_DATA_OFS, {4'h0, lat});
      wr(mpb_pkg::P2_DIR_OFS, {4'hf, dir});
      wr(mpb_pkg::P2_PU_OFS, {4'h0, pu});
      repeat (3) @(posedge core_clk);
      rd(mpb_pkg::P2_DATA_OFS);
      check(v, exp_data(dir, lat, p2Ext));
      check({4'h0, port2Oen}, {4'h0, dir});
      check({4'h0, port2Out & ~dir}, {4'h0, lat & ~dir});
      check({4'h0, port2PullUp}, {4'h0, pu & dir});
      check({7'h0, extInterrupt0}, {7'h0, dir[1] ? p2Ext[1] : lat[1]});
      check({7'h0, timerCaptureA}, {7'h0, dir[0] ? p2Ext[0] : lat[0]});
      rd(mpb_pkg::P4_DATA_OFS);
      check(v, {4'h0, p4Ext[1], 2'b00, p4Ext[0]});
    end
    for (int s = 0; s < 4; s++) begin
      optRst = s[0];
      do_reset(2'(s));
      osc = {s == 1 || s == 2, s == 1};
      p2En <= 4'h0;
      rd(mpb_pkg::CLKSEL_OFS);
      check({6'h0, v[1:0]}, {6'h0, 2'(s)});
      check({7'h0, v[2]}, {7'h0, optRst});
      check({6'h0, oscInputSel, oscOutputSel}, {6'h0, osc});
      wr(mpb_pkg::P2_PU_OFS, 8'h0f);
      wr(mpb_pkg::P2_ALT_OFS, 8'h0f);
      check({4'h0, port2PullUp}, {4'h0, ~osc, 2'b11});
      check({4'h0, analogInputEn}, {4'h0, ~osc, 2'b11});
      {tmrA, tmrH} <= 2'($random(seed));
      wr(mpb_pkg::P2_DIR_OFS, 8'hf0);
      check({4'h0, port2Oen}, {4'h0, 2'b11, 2'b00});
      check({6'h0, port2Out[1:0]}, {6'h0, tmrA, tmrH});
      wr(mpb_pkg::P2_ALT_OFS, 8'h00);
      check({4'h0, port2Oen}, {4'h0, osc, 2'b00});
    end
    wrap_up();
  end
endmodule : mpb_port_block_bench

// ---- mpb_port_block_props.sv ----
// assertions on the port block pins and register reads
`timescale 1ns/1ns
module mpb_port_block_props (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rstn,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic       regRd,
  input wire logic [7:0] regRdata,
  // pins and alternate functions
  input wire logic [3:0] port2Oen,
  input wire logic [3:0] port2PullUp,
  input wire logic [3:0] port2PullDown,
  input wire logic       port3Pin2In,
  input wire logic       port3Pin4PullUp,
  input wire logic [3:0] analogInputEn,
  input wire logic       oscInputSel,
  input wire logic       oscOutputSel,
  input wire logic       extInterrupt1
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  pd_in_reset_a: assert property (!$past(rstn) |-> $past(port2PullDown) == 4'hc)
    else $error("no pull-down in reset");
  pu_in_reset_a: assert property (!$past(rstn) |-> $past(port3Pin4PullUp))
    else $error("no pull-up in reset");
  dir_after_reset_a: assert property (!$past(rstn) |-> port2Oen == 4'hf)
    else $error("port not input after reset");
  pu_out_off_a: assert property ((port2PullUp & ~port2Oen) == 4'h0)
    else $error("pull-up on output pin");
  osc_in_pin_a: assert property (
    oscInputSel |-> port2Oen[3] && !port2PullUp[3] && !analogInputEn[3])
    else $error("oscillator pin used as port");
  osc_fixed_a: assert property (
    $past(rstn, 3) |-> $stable(oscInputSel) && $stable(oscOutputSel))
    else $error("clock source changed at run time");
  irq_follow_a: assert property ($past(rstn, 3) |-> extInterrupt1 == $past(port3Pin2In, 2))
    else $error("interrupt input not following pin");
  adc_in_only_a: assert property ((analogInputEn & ~port2Oen) == 4'h0)
    else $error("analog input on output pin");
  dir3_read_a: assert property (
    $past(regRd) && $past(regAddr) == 8'h23 |-> (regRdata | 8'h04) == 8'hff)
    else $error("unused direction bit not one");
  cover property (oscInputSel && !oscOutputSel);
  cover property (oscOutputSel);
  cover property ($past(regRd) && $past(regAddr) == 8'h02);
endmodule : mpb_port_block_props
bind mpb_port_block mpb_port_block_props u_props (.core_clk, .rstn, .regAddr, .regRd,
  .regRdata, .port2Oen, .port2PullUp, .port2PullDown, .port3Pin2In, .port3Pin4PullUp,
  .analogInputEn, .oscInputSel, .oscOutputSel, .extInterrupt1);

// ---- mpb_sync.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module mpb_sync #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rstn,
  // data
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] meta_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      meta_q  <= '0;
      syncOut <= '0;
    end else begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule : mpb_sync
